// ---- iesw_state_words.sv ----
// instrument error and status word builder with wishbone register access
`timescale 1ns/1ps
`include "iesw_defines.svh"

module iesw_state_words #(
  parameter int BREAK_CYCLES = `IESW_BREAK_MIN_US * (`IESW_MCLK_HZ / 1000000)
) (
  input wire logic mclk_in, // system clock, 10 MHz
  input wire logic reset_in, // synchronous reset, active high
  input wire iesw_pkg::iesw_wb_req_s wb_req_in, // wishbone request group
  output logic [31:0] wb_dat_out, // wishbone read data
  output logic wb_ack_out, // wishbone acknowledge
  input wire iesw_pkg::iesw_sense_s sense_in, // fault and attitude inputs
  input wire logic supply_ok_in, // supply voltage adequate
  input wire logic power_up_in, // pulse: power has just been applied
  input wire logic [15:0] off_ms_in, // length of the preceding power gap, ms
  input wire logic rtc_wake_in, // pulse: clock wakeup from sleep
  input wire logic uart_rx_in, // host serial line, idle high
  input wire logic record_req_in, // pulse: an output record is being built
  output logic core_reset_out, // holds the rest of the instrument in reset
  output logic [7:0] fault_word_out, // live fault word
  output logic [7:0] cond_word_out, // live condition word
  output logic earth_frame_out, // one when earth frame output is in effect
  output logic [15:0] heading_out, // reported heading, 0.1 degree units
  output logic [7:0] rec_fault_out, // fault word stamped into last record
  output logic [7:0] rec_cond_out, // condition word stamped into last record
  output logic rec_valid_out // pulse: record words updated
);
  import iesw_pkg::*;

  iesw_state_s s;
  iesw_state_s next_s;
  logic [15:0] hist_rdata;
  logic hist_wr;
  logic [7:0] fault_now;
  logic [7:0] cond_now;
  logic req_live;

  localparam logic [13:0] BREAK_CNT = 14'(BREAK_CYCLES);

  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic in_hist(input logic [7:0] a);
    in_hist = (a >= `IESW_ADR_HIST_LO) && (a <= `IESW_ADR_HIST_HI);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // word assembly

  always_comb begin
    // bit index equals position from the right, bit 0 least significant
    fault_now = 8'h00;
    fault_now[7] = s.cfg[`IESW_CFG_EARTH_BIT] & ~sense_in.compass_ok;
    fault_now[6] = ~sense_in.tilt_ok;
    fault_now[5] = sense_in.beam_order_fault;
    fault_now[4] = sense_in.flash_fault;
    fault_now[3] = sense_in.buf_overflow;
    fault_now[2] = ~&sense_in.aux_ok;
    fault_now[1] = |sense_in.proc_fault;
    fault_now[0] = ~sense_in.compass_ok;
  end

  always_comb begin
    cond_now = 8'h00;
    cond_now[7:6] = s.cfg[`IESW_CFG_PWR_LSB +: 2];
    cond_now[5:4] = s.wake;
    cond_now[3] = mag16(sense_in.roll) > `IESW_TILT_LIMIT_DDEG;
    cond_now[2] = mag16(sense_in.pitch) > `IESW_TILT_LIMIT_DDEG;
    cond_now[1] = s.cfg[`IESW_CFG_VRANGE_LSB +: 3] == `IESW_VRANGE_LOWEST;
    // cable end low means probe up, reported as down
    cond_now[0] = sense_in.cable_end_down;
  end

  assign req_live = wb_req_in.cyc & wb_req_in.stb;
  assign hist_wr = record_req_in;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;
    next_s.rec_valid = 1'b0;
    next_s.fault = fault_now;
    next_s.cond = cond_now;
    next_s.earth_frame = s.cfg[`IESW_CFG_EARTH_BIT] & sense_in.compass_ok;
    next_s.heading = sense_in.compass_ok ? sense_in.heading : `IESW_HEADING_FIXED;

    // break detector: the line held low long enough is a host break
    if (uart_rx_in) begin
      next_s.brk_cnt = 14'h0000;
      next_s.brk_hold = 1'b0;
    end else if (s.brk_cnt >= BREAK_CNT - 14'h0001) begin
      next_s.brk_hold = 1'b1;
    end else begin
      next_s.brk_cnt = s.brk_cnt + 14'h0001;
    end

    // wakeup source; bad power outranks every other cause
    if (!supply_ok_in) begin
      next_s.wake = `IESW_WAKE_BAD;
    end else if (power_up_in) begin
      // a short gap cannot be told from a brownout
      next_s.wake = (off_ms_in >= `IESW_PWR_OFF_MIN_MS) ? `IESW_WAKE_POWER
                                                        : `IESW_WAKE_BAD;
    end else if (s.brk_hold) begin
      next_s.wake = `IESW_WAKE_BREAK;
    end else if (rtc_wake_in) begin
      next_s.wake = `IESW_WAKE_RTC;
    end

    // record stamping uses the registered words, so both match their outputs
    if (record_req_in) begin
      next_s.rec_fault = s.fault;
      next_s.rec_cond = s.cond;
      next_s.rec_valid = 1'b1;
      next_s.wptr = s.wptr + 4'h1;
      next_s.rec_cnt = s.rec_cnt + 16'h0001;
    end

    // wishbone slave: one wait state so history reads see registered memory
    unique case (s.bus)
      BUS_IDLE: begin
        if (req_live) begin
          next_s.bus = BUS_PEND;
        end
      end
      BUS_PEND: begin
        next_s.bus = BUS_ACK;
        next_s.rdat = 32'h00000000;
        if (!wb_req_in.we) begin
          if (in_hist(wb_req_in.adr)) begin
            next_s.rdat = {16'h0000, hist_rdata};
          end else begin
            unique case (wb_req_in.adr)
              `IESW_ADR_FAULT: next_s.rdat = {24'h000000, s.fault};
              `IESW_ADR_COND: next_s.rdat = {24'h000000, s.cond};
              `IESW_ADR_CFG: next_s.rdat = {24'h000000, s.cfg};
              `IESW_ADR_HEADING: next_s.rdat = {16'h0000, s.heading};
              `IESW_ADR_RECCNT: next_s.rdat = {16'h0000, s.rec_cnt};
              default: next_s.rdat = 32'h00000000;
            endcase
          end
        end
      end
      BUS_ACK: begin
        next_s.bus = BUS_IDLE;
        // the write lands on the edge where the master sees ack
        if (wb_req_in.we && wb_req_in.sel[0] && wb_req_in.adr == `IESW_ADR_CFG) begin
          next_s.cfg = wb_req_in.dat[7:0] & `IESW_CFG_MASK;
        end
      end
      default: next_s.bus = BUS_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s <= '0;
      s.bus <= BUS_IDLE;
      s.cfg <= `IESW_CFG_RESET;
      s.wake <= `IESW_WAKE_POWER;
      s.heading <= `IESW_HEADING_FIXED;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // history of stamped words

  iesw_hist_mem u_hist (
    .mclk_in(mclk_in),
    .wr_en_in(hist_wr),
    .wr_addr_in(s.wptr),
    .wr_data_in({s.fault, s.cond}),
    .rd_addr_in(wb_req_in.adr[5:2]),
    .rd_data_out(hist_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // reset and bad supply hold it at once; the break hold is registered and drops a cycle after the line idles high
  assign core_reset_out = reset_in | ~supply_ok_in | s.brk_hold;
  assign wb_ack_out = (s.bus == BUS_ACK);
  assign wb_dat_out = s.rdat;
  assign fault_word_out = s.fault;
  assign cond_word_out = s.cond;
  assign earth_frame_out = s.earth_frame;
  assign heading_out = s.heading;
  assign rec_fault_out = s.rec_fault;
  assign rec_cond_out = s.rec_cond;
  assign rec_valid_out = s.rec_valid;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  coord_fallback_a: assert property ($past(!reset_in) |->
      fault_word_out[7] == $past(s.cfg[`IESW_CFG_EARTH_BIT] && !sense_in.compass_ok)
      && !(earth_frame_out && fault_word_out[0]))
    else $error("frame fallback or bit 7 wrong");

  tilt_bit_a: assert property ($past(!reset_in) |->
      fault_word_out[6] == !$past(sense_in.tilt_ok))
    else $error("tilt response bit wrong");

  beam_flash_a: assert property ($past(!reset_in) |->
      fault_word_out[5:4] == {$past(sense_in.beam_order_fault), $past(sense_in.flash_fault)})
    else $error("beam or flash bit wrong");

  overflow_bit_a: assert property ($past(!reset_in) |->
      fault_word_out[3] == $past(sense_in.buf_overflow))
    else $error("overflow bit wrong");

  sensor_any_a: assert property ($past(!reset_in) && $past(!(&sense_in.aux_ok)) |->
      fault_word_out[2])
    else $error("aux sensor fault not flagged");

  proc_any_a: assert property ($past(!reset_in) |->
      fault_word_out[1] == $past(|sense_in.proc_fault))
    else $error("processing fault bit wrong");

  heading_fixed_a: assert property (fault_word_out[0] |->
      heading_out == `IESW_HEADING_FIXED && !earth_frame_out)
    else $error("heading not fixed on compass loss");

  power_level_a: assert property ($past(!reset_in) && $stable(s.cfg) |=>
      cond_word_out[7:6] == $past(s.cfg[1:0], 2))
    else $error("power level field wrong");

  badpwr_hold_a: assert property (!supply_ok_in |-> core_reset_out
      ##1 s.wake == `IESW_WAKE_BAD)
    else $error("bad power not held or not reported");

  break_code_a: assert property (s.brk_hold && supply_ok_in && !power_up_in
      |-> core_reset_out ##1 s.wake == `IESW_WAKE_BREAK)
    else $error("break not held or not reported");

  rtc_code_a: assert property (rtc_wake_in && supply_ok_in && !power_up_in
      && !s.brk_hold |=> s.wake == `IESW_WAKE_RTC)
    else $error("clock wakeup not reported");

  roll_range_a: assert property ($past(!reset_in) |->
      cond_word_out[3] == ($past(mag16(sense_in.roll)) > `IESW_TILT_LIMIT_DDEG))
    else $error("roll range bit wrong");

  orient_bit_a: assert property ($past(!reset_in) |->
      cond_word_out[0] == $past(sense_in.cable_end_down))
    else $error("orientation bit wrong");

  record_copy_a: assert property (record_req_in |=> rec_valid_out
      && rec_fault_out == $past(fault_word_out) && rec_cond_out == $past(cond_word_out))
    else $error("record words not copied");

  bus_ack_a: assert property (s.bus == BUS_IDLE && req_live |-> !wb_ack_out ##2 wb_ack_out
      ##1 !wb_ack_out)
    else $error("ack timing wrong");

endmodule

// ---- iesw_defines.svh ----
// register offsets, field positions, reset values and timing figures for the state words
`ifndef IESW_DEFINES_SVH
`define IESW_DEFINES_SVH

`define IESW_ADR_FAULT 8'h00
`define IESW_ADR_COND 8'h04
`define IESW_ADR_CFG 8'h08
`define IESW_ADR_HEADING 8'h0c
`define IESW_ADR_RECCNT 8'h10
`define IESW_ADR_HIST_LO 8'h40
`define IESW_ADR_HIST_HI 8'h7c

`define IESW_CFG_RESET 8'h00
`define IESW_CFG_PWR_LSB 0
`define IESW_CFG_EARTH_BIT 2
`define IESW_CFG_VRANGE_LSB 3
`define IESW_CFG_MASK 8'h3f
`define IESW_VRANGE_LOWEST 3'h0

`define IESW_WAKE_BAD 2'h0
`define IESW_WAKE_POWER 2'h1
`define IESW_WAKE_BREAK 2'h2
`define IESW_WAKE_RTC 2'h3

`define IESW_HEADING_FIXED 16'h0384
`define IESW_TILT_LIMIT_DDEG 16'h012c

`define IESW_MCLK_HZ 10000000
`define IESW_PWR_OFF_MIN_MS 16'h07d0
`define IESW_BREAK_MIN_US 1000

`define IESW_HIST_DEPTH 16
`define IESW_HIST_AW 4

`endif

// ---- iesw_pkg.sv ----
// types shared by the state word block
package iesw_pkg;

  typedef enum logic [1:0] {BUS_IDLE, BUS_PEND, BUS_ACK} iesw_bus_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } iesw_wb_req_s;

  typedef struct packed {
    logic compass_ok;
    logic tilt_ok;
    logic beam_order_fault;
    logic flash_fault;
    logic buf_overflow;
    logic [3:0] aux_ok;
    logic [3:0] proc_fault;
    logic cable_end_down;
    logic signed [15:0] roll;
    logic signed [15:0] pitch;
    logic [15:0] heading;
  } iesw_sense_s;

  typedef struct packed {
    iesw_bus_e bus;
    logic [31:0] rdat;
    logic [7:0] fault;
    logic [7:0] cond;
    logic [15:0] heading;
    logic earth_frame;
    logic [1:0] wake;
    logic [13:0] brk_cnt;
    logic brk_hold;
    logic [7:0] cfg;
    logic [7:0] rec_fault;
    logic [7:0] rec_cond;
    logic rec_valid;
    logic [3:0] wptr;
    logic [15:0] rec_cnt;
  } iesw_state_s;

endpackage

// ---- iesw_hist_mem.sv ----
// small history memory of emitted state word pairs, registered read
`timescale 1ns/1ps
`include "iesw_defines.svh"

module iesw_hist_mem (
  input wire logic mclk_in, // system clock
  input wire logic wr_en_in, // write strobe
  input wire logic [`IESW_HIST_AW-1:0] wr_addr_in, // write slot
  input wire logic [15:0] wr_data_in, // fault word high, condition word low
  input wire logic [`IESW_HIST_AW-1:0] rd_addr_in, // read slot
  output logic [15:0] rd_data_out // read data, one cycle after address
);

  logic [15:0] mem [`IESW_HIST_DEPTH];

  // no reset on the array: contents are only meaningful once written
  always_ff @(posedge mclk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end

endmodule

// ---- iesw_host_model.sv ----
// host side model: sends line breaks and keeps the words of the last record
`timescale 1ns/1ps

module iesw_host_model (
  input wire logic mclk_in, // system clock
  input wire logic break_in, // hold the line in break while high
  input wire logic rec_valid_in, // record words updated
  input wire logic [7:0] rec_fault_in, // stamped fault word
  input wire logic [7:0] rec_cond_in, // stamped condition word
  output logic uart_rx_out, // serial line toward the device
  output logic [7:0] got_fault_out, // fault word of last record
  output logic [7:0] got_cond_out // condition word of last record
);
  // break is a held low level; between breaks the line idles high
  // one process drives every output; the line is settled by the first edge, inside reset
  always @(posedge mclk_in) begin
    uart_rx_out <= !break_in;
    if (rec_valid_in) begin
      got_fault_out <= rec_fault_in;
      got_cond_out <= rec_cond_in;
    end
  end
endmodule

// ---- tb_iesw_state_words.sv ----
// self-checking bench for the state word builder
`timescale 1ns/1ps
`include "iesw_defines.svh"

module tb_iesw_state_words;
  import iesw_pkg::*;
  typedef struct packed {
    logic [13:0] flg;
    logic [15:0] roll;
    logic [15:0] pitch;
    logic [7:0] f;
    logic [7:0] c;
  } iesw_row_s;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  iesw_wb_req_s wb_req = '0;
  iesw_sense_s sense = '0;
  logic supply_ok = 1'b1;
  logic power_up = 1'b0;
  logic rtc_wake = 1'b0;
  logic record_req = 1'b0;
  logic brk = 1'b0;
  logic [15:0] off_ms = 16'h0000;
  logic uart_rx, wb_ack, core_reset, earth, rec_valid;
  logic [31:0] wb_dat, rd;
  logic [7:0] fault_w, cond_w, rec_fault, rec_cond, got_fault, got_cond, tmp;
  logic [15:0] heading;
  int fails = 0;
  int compares = 0;
  iesw_row_s rows [12];

  // short break count keeps the break scenario brief
  iesw_state_words #(.BREAK_CYCLES(8)) u_iesw_state_words (
    .mclk_in(mclk_in), .reset_in(reset_in), .wb_req_in(wb_req), .wb_dat_out(wb_dat),
    .wb_ack_out(wb_ack), .sense_in(sense), .supply_ok_in(supply_ok), .power_up_in(power_up),
    .off_ms_in(off_ms), .rtc_wake_in(rtc_wake), .uart_rx_in(uart_rx),
    .record_req_in(record_req), .core_reset_out(core_reset), .fault_word_out(fault_w),
    .cond_word_out(cond_w), .earth_frame_out(earth), .heading_out(heading),
    .rec_fault_out(rec_fault), .rec_cond_out(rec_cond), .rec_valid_out(rec_valid));

  iesw_host_model u_iesw_host_model (
    .mclk_in(mclk_in), .break_in(brk), .rec_valid_in(rec_valid), .rec_fault_in(rec_fault),
    .rec_cond_in(rec_cond), .uart_rx_out(uart_rx), .got_fault_out(got_fault),
    .got_cond_out(got_cond));

  always #50 mclk_in = ~mclk_in;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // no fixed latency assumed: only the watchdog ends the wait for ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge mclk_in);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do @(posedge mclk_in); while (wb_ack !== 1'b1);
    rd = wb_dat;
    wb_req <= '0;
    @(posedge mclk_in);
  endtask

  task automatic wake(input logic [1:0] kind, input logic [15:0] ms, input logic [1:0] exp);
    @(posedge mclk_in);
    rtc_wake <= (kind == 2'h3);
    power_up <= (kind == 2'h1);
    off_ms <= ms;
    supply_ok <= (kind != 2'h0);
    #1;
    chk({15'h0, core_reset}, {15'h0, kind == 2'h0});
    @(posedge mclk_in);
    rtc_wake <= 1'b0;
    power_up <= 1'b0;
    supply_ok <= 1'b1;
    @(posedge mclk_in);
    #1;
    chk({14'h0, cond_w[5:4]}, {14'h0, exp});
    $display("wake test %0d done", kind);
  endtask

  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(5000 * 100);
    fails++;
    complete_run();
  end

  initial begin
    rows = '{'{14'h31e0, 16'h0000, 16'h0000, 8'h00, 8'h90}, '{14'h11e0, 16'h0, 16'h0, 8'h81, 8'h90},
      '{14'h21e0, 16'h0, 16'h0, 8'h40, 8'h90}, '{14'h39e0, 16'h0, 16'h0, 8'h20, 8'h90},
      '{14'h35e0, 16'h0, 16'h0, 8'h10, 8'h90}, '{14'h33e0, 16'h0, 16'h0, 8'h08, 8'h90},
      '{14'h31c0, 16'h0, 16'h0, 8'h04, 8'h90}, '{14'h31e2, 16'h0, 16'h0, 8'h02, 8'h90},
      '{14'h31e1, 16'h0, 16'h0, 8'h00, 8'h91}, '{14'h31e0, 16'h012d, 16'h012c, 8'h00, 8'h98},
      '{14'h31e0, 16'hfed4, 16'hfed3, 8'h00, 8'h94}, '{14'h31e0, 16'h012c, 16'h012c, 8'h00, 8'h90}};
    repeat (9) @(posedge mclk_in);
    #1;
    chk({15'h0, core_reset}, 16'h0001);
    chk(heading, `IESW_HEADING_FIXED);
    @(posedge mclk_in);
    reset_in <= 1'b0;
    $display("reset test done");
    wb(1'b1, `IESW_ADR_CFG, 32'h0000_000e);
    foreach (rows[i]) begin
      @(posedge mclk_in);
      sense <= {rows[i].flg, rows[i].roll, rows[i].pitch, 16'h0123};
      repeat (2) @(posedge mclk_in);
      #1;
      chk({fault_w, cond_w}, {rows[i].f, rows[i].c});
      chk({15'h0, earth}, {15'h0, rows[i].flg[13]});
      chk(heading, rows[i].flg[13] ? 16'h0123 : `IESW_HEADING_FIXED);
      wb(1'b0, `IESW_ADR_FAULT, 32'h0);
      tmp = rd[7:0];
      wb(1'b0, `IESW_ADR_COND, 32'h0);
      chk({tmp, rd[7:0]}, {rows[i].f, rows[i].c});
      @(posedge mclk_in);
      record_req <= 1'b1;
      @(posedge mclk_in);
      record_req <= 1'b0;
      #1;
      chk({15'h0, rec_valid}, 16'h0001);
      @(posedge mclk_in);
      #1;
      chk({got_fault, got_cond}, {rows[i].f, rows[i].c});
      chk({15'h0, rec_valid}, 16'h0000);
      $display("row %0d done", i);
    end
    // one record per row, stored in order from slot 0
    wb(1'b0, `IESW_ADR_RECCNT, 32'h0);
    chk(rd[15:0], 16'h000c);
    wb(1'b0, `IESW_ADR_HIST_LO + 8'h04, 32'h0);
    chk(rd[15:0], 16'h8190);
    wb(1'b0, `IESW_ADR_HEADING, 32'h0);
    chk(rd[15:0], 16'h0123);
    $display("record readback test done");
    for (int p = 0; p < 4; p++) begin
      wb(1'b1, `IESW_ADR_CFG, {30'h0, p[1:0]});
      @(posedge mclk_in);
      #1;
      chk({8'h0, cond_w}, {8'h0, p[1:0], 6'h12});
    end
    wb(1'b1, `IESW_ADR_CFG, 32'hffff_ffff);
    wb(1'b0, `IESW_ADR_CFG, 32'h0);
    chk(rd[15:0], 16'h003f);
    wb(1'b1, `IESW_ADR_FAULT, 32'hffff_ffff);
    wb(1'b0, `IESW_ADR_FAULT, 32'h0);
    chk(rd[15:0], 16'h0000);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd[15:0], 16'h0000);
    $display("register test done");
    wake(2'h3, 16'h0000, 2'h3);
    wake(2'h1, 16'h07cf, 2'h0);
    wake(2'h1, `IESW_PWR_OFF_MIN_MS, 2'h1);
    wake(2'h0, 16'h0000, 2'h0);
    @(posedge mclk_in);
    brk <= 1'b1;
    repeat (5) @(posedge mclk_in);
    #1;
    chk({15'h0, core_reset}, 16'h0000);
    repeat (7) @(posedge mclk_in);
    #1;
    chk({15'h0, core_reset}, 16'h0001);
    @(posedge mclk_in);
    brk <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    chk({14'h0, core_reset, 1'b0}, 16'h0000);
    chk({14'h0, cond_w[5:4]}, 16'h0002);
    $display("break test done");
    @(posedge mclk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    chk({rec_fault, rec_cond}, 16'h0000);
    @(posedge mclk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    chk({8'h0, cond_w}, 16'h0012);
    $display("second reset test done");
    complete_run();
  end
endmodule
